// ===== design/rth_pkg.sv
/*
  Package for the upper runtime register block: offsets, reset values,
  access masks and the decoded host I/O request carrier.
  Assumes an external LPC protocol engine that presents decoded I/O cycles.
*/
package rth_pkg;

  typedef logic [7:0] rth_byte_t;

  // decoded host I/O cycle, valid for one clock
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } rth_io_req_s;

  // block span and window of this block
  localparam logic [15:0] BLK_SPAN       = 16'h0080;
  localparam logic [6:0]  UPPER_BASE     = 7'h40;
  localparam int          UPPER_COUNT    = 64;

  // register offsets
  localparam logic [6:0] OFF_DEV_DISABLE       = 7'h22;
  localparam logic [6:0] OFF_ALT_PIN_CONFIG_B  = 7'h3E;
  localparam logic [6:0] OFF_PIN_CTL_57        = 7'h40;
  localparam logic [6:0] OFF_PIN_CTL_60        = 7'h40;
  localparam logic [6:0] OFF_PIN_CTL_62        = 7'h40;
  localparam logic [6:0] OFF_PIN_CTL_52        = 7'h41;
  localparam logic [6:0] OFF_PIN_CTL_53        = 7'h41;
  localparam logic [6:0] OFF_PIN_CTL_54        = 7'h43;
  localparam logic [6:0] OFF_PIN_CTL_55        = 7'h43;
  localparam logic [6:0] OFF_PIN_CTL_56        = 7'h44;
  localparam logic [6:0] OFF_PIN_CTL_61        = 7'h47;
  localparam logic [6:0] OFF_PIN_GROUP_ONE     = 7'h4B;
  localparam logic [6:0] OFF_PIN_GROUP_TWO     = 7'h4C;
  localparam logic [6:0] OFF_PIN_GROUP_THREE   = 7'h4D;
  localparam logic [6:0] OFF_PIN_GROUP_FOUR    = 7'h4E;
  localparam logic [6:0] OFF_PIN_GROUP_FIVE    = 7'h4F;
  localparam logic [6:0] OFF_PIN_GROUP_SIX     = 7'h50;
  localparam logic [6:0] OFF_WDT_TIMEOUT_SEL   = 7'h52;
  localparam logic [6:0] OFF_WDT_COUNT_VALUE   = 7'h53;
  localparam logic [6:0] OFF_WDT_CONFIG        = 7'h54;
  localparam logic [6:0] OFF_WDT_CONTROL       = 7'h55;
  localparam logic [6:0] OFF_FAN_OUTPUT        = 7'h56;
  localparam logic [6:0] OFF_FAN_CONTROL       = 7'h58;
  localparam logic [6:0] OFF_FAN_SPEED_COUNT   = 7'h59;
  localparam logic [6:0] OFF_FAN_PRELOAD       = 7'h5B;
  localparam logic [6:0] OFF_INDICATOR_ONE     = 7'h5D;
  localparam logic [6:0] OFF_INDICATOR_TWO     = 7'h5E;
  localparam logic [6:0] OFF_WAKE_KEY_CODE     = 7'h5F;
  localparam logic [6:0] OFF_PWR_MGMT_ONE      = 7'h60;
  localparam logic [6:0] OFF_PWR_MGMT_TWO      = 7'h61;
  localparam logic [6:0] OFF_SMI_STATUS_SEVEN  = 7'h64;
  localparam logic [6:0] OFF_SMI_ENABLE_SEVEN  = 7'h66;
  localparam logic [6:0] OFF_WAKE_STATUS_SEVEN = 7'h68;
  localparam logic [6:0] OFF_WAKE_ENABLE_SEVEN = 7'h6C;
  localparam logic [6:0] OFF_RESERVED_FIRST    = 7'h6D;

  // standby power-on reset values
  localparam rth_byte_t RST_PIN_CTL      = 8'h01;
  localparam rth_byte_t RST_FAN_CONTROL  = 8'h10;
  localparam rth_byte_t RST_ZERO         = 8'h00;

  // access masks
  localparam rth_byte_t MASK_ALL          = 8'hFF;
  localparam rth_byte_t MASK_NONE         = 8'h00;
  localparam rth_byte_t WATCHDOG_CONTROL_STORE    = 8'h03;
  localparam rth_byte_t WATCHDOG_CONTROL_READ     = 8'h0B;
  localparam rth_byte_t WATCHDOG_CONTROL_KEEP_HR  = 8'h01;
  localparam int        WATCHDOG_CONTROL_KICK_BIT = 2;
  localparam int        WATCHDOG_CONTROL_STAT_BIT = 3;
  localparam rth_byte_t GRP_TWO_FAN_BIT   = 8'h08;
  localparam rth_byte_t ALT_PIN_MODE_MASK = 8'h0C;
  localparam logic [1:0] ALT_PIN_MODE_LOCK = 2'b01;
  localparam int        ALT_PIN_MODE_LSB  = 2;

endpackage : rth_pkg

// ===== design/rth_upper_regs.sv
/*
  Upper runtime register block (offsets 0x40..0x7F), plus the device disable
  and pin 43 control registers whose behaviour is tied to this block.
  Assumes: rst is the standby power-on reset; main_por, hard_reset and
  soft_reset are one-cycle pulses from ref_clk logic; io_req comes from an
  LPC cycle decoder on ref_clk; printer_ack_input and alt_pin_b_input are pins.
*/
// Behaviour
// - reserved bits of every register read back as zero
// - offsets 0x6D to 0x7F read zero and ignore writes
// - watchdog control holds read-only, write-only and read-write bits
// - hard reset clears watchdog control except status bit 3 and bit 0, which is kept until power-on reset
// - device disable ignores writes while pin 43 mode is 01 and pin high
// - pin group two data bit 3 cleared by every power-on and hard reset
// - pin 43 control bits 3:2 cleared by every power-on and hard reset
// - parallel interrupt level held at one while the port is not activated
// - parallel interrupt level follows printer acknowledge pin when activated
// - block answers at programmed base plus offset, state kept on standby power
`timescale 1ns/1ps
`default_nettype none

module rth_upper_regs (
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  input  wire logic                        main_por,
  input  wire logic                        hard_reset,
  input  wire logic                        soft_reset,
  input  wire logic [15:0]                 base_addr,
  input  wire rth_pkg::rth_io_req_s        io_req,
  input  wire logic                        par_port_active,
  input  wire logic                        printer_ack_input,
  input  wire logic                        alt_pin_b_input,
  input  wire logic                        wdt_status_in,
  input  wire rth_pkg::rth_byte_t          fan_speed_count,
  output logic     [7:0]                   io_rdata_q,
  output logic                             io_ack_q,
  output logic     [63:0][7:0]             upper_regs_q,
  output logic     [7:0]                   dev_disable_q,
  output logic     [7:0]                   alt_pin_config_b_q,
  output logic                             wdt_kick_q,
  output logic                             parallel_irq_level_q
);

  // storage mask: bits that hold written data
  function automatic rth_pkg::rth_byte_t store_mask(input logic [6:0] off);
    rth_pkg::rth_byte_t m;
    m = rth_pkg::MASK_NONE;
    if (off >= rth_pkg::OFF_RESERVED_FIRST) begin
      m = rth_pkg::MASK_NONE;
    end else begin
      unique case (off)
        rth_pkg::OFF_PIN_CTL_57, rth_pkg::OFF_PIN_CTL_52, rth_pkg::OFF_PIN_CTL_54,
        rth_pkg::OFF_PIN_CTL_56, rth_pkg::OFF_PIN_CTL_61,
        rth_pkg::OFF_PIN_GROUP_ONE, rth_pkg::OFF_PIN_GROUP_TWO, rth_pkg::OFF_PIN_GROUP_THREE,
        rth_pkg::OFF_PIN_GROUP_FOUR, rth_pkg::OFF_PIN_GROUP_FIVE, rth_pkg::OFF_PIN_GROUP_SIX,
        rth_pkg::OFF_WDT_TIMEOUT_SEL, rth_pkg::OFF_WDT_COUNT_VALUE, rth_pkg::OFF_WDT_CONFIG,
        rth_pkg::OFF_FAN_OUTPUT, rth_pkg::OFF_FAN_CONTROL, rth_pkg::OFF_FAN_PRELOAD,
        rth_pkg::OFF_INDICATOR_ONE, rth_pkg::OFF_INDICATOR_TWO, rth_pkg::OFF_WAKE_KEY_CODE,
        rth_pkg::OFF_PWR_MGMT_ONE, rth_pkg::OFF_PWR_MGMT_TWO,
        rth_pkg::OFF_SMI_STATUS_SEVEN, rth_pkg::OFF_SMI_ENABLE_SEVEN,
        rth_pkg::OFF_WAKE_STATUS_SEVEN, rth_pkg::OFF_WAKE_ENABLE_SEVEN:
          m = rth_pkg::MASK_ALL;
        rth_pkg::OFF_WDT_CONTROL: m = rth_pkg::WATCHDOG_CONTROL_STORE;
        default: m = rth_pkg::MASK_NONE;
      endcase
    end
    return m;
  endfunction : store_mask

  // read mask: bits visible to the host
  function automatic rth_pkg::rth_byte_t read_mask(input logic [6:0] off);
    rth_pkg::rth_byte_t m;
    m = store_mask(off);
    if (off == rth_pkg::OFF_WDT_CONTROL) begin
      m = rth_pkg::WATCHDOG_CONTROL_READ;
    end else if (off == rth_pkg::OFF_FAN_SPEED_COUNT) begin
      m = rth_pkg::MASK_ALL;
    end
    return m;
  endfunction : read_mask

  // standby power-on value
  function automatic rth_pkg::rth_byte_t standby_value(input logic [6:0] off);
    rth_pkg::rth_byte_t v;
    v = rth_pkg::RST_ZERO;
    unique case (off)
      rth_pkg::OFF_PIN_CTL_57, rth_pkg::OFF_PIN_CTL_52, rth_pkg::OFF_PIN_CTL_54,
      rth_pkg::OFF_PIN_CTL_56, rth_pkg::OFF_PIN_CTL_61:
        v = rth_pkg::RST_PIN_CTL;
      rth_pkg::OFF_FAN_CONTROL: v = rth_pkg::RST_FAN_CONTROL;
      default: v = rth_pkg::RST_ZERO;
    endcase
    return v;
  endfunction : standby_value

  // bits cleared by hard reset or main power-on reset; power-on also clears the kept bit
  function automatic rth_pkg::rth_byte_t hard_clear(input logic [6:0] off, input logic por);
    rth_pkg::rth_byte_t m;
    m = rth_pkg::MASK_NONE;
    unique case (off)
      rth_pkg::OFF_PIN_CTL_53,
      rth_pkg::OFF_WDT_TIMEOUT_SEL, rth_pkg::OFF_WDT_COUNT_VALUE, rth_pkg::OFF_WDT_CONFIG:
        m = rth_pkg::MASK_ALL;
      rth_pkg::OFF_WDT_CONTROL: m = por ? rth_pkg::MASK_ALL : ~rth_pkg::WATCHDOG_CONTROL_KEEP_HR;
      rth_pkg::OFF_PIN_GROUP_TWO: m = rth_pkg::GRP_TWO_FAN_BIT;
      default: m = rth_pkg::MASK_NONE;
    endcase
    return m;
  endfunction : hard_clear

  logic [15:0] rel_off;
  logic        in_block;
  logic [6:0]  off;
  logic        upper_hit;
  logic        dis_hit;
  logic        alt_hit;
  logic        any_hit;
  logic        wr_cyc;
  logic        rd_cyc;
  logic        warm_reset;
  logic        dis_locked;
  logic        ack_meta_q;
  logic        ack_sync_q;
  logic        pin_meta_q;
  logic        pin_sync_q;
  logic [7:0]  rd_value;

  // decode relative to the programmed base
  assign rel_off    = io_req.addr - base_addr;
  assign in_block   = rel_off < rth_pkg::BLK_SPAN;
  assign off        = rel_off[6:0];
  assign upper_hit  = in_block && (off >= rth_pkg::UPPER_BASE);
  assign dis_hit    = in_block && (off == rth_pkg::OFF_DEV_DISABLE);
  assign alt_hit    = in_block && (off == rth_pkg::OFF_ALT_PIN_CONFIG_B);
  assign any_hit    = upper_hit || dis_hit || alt_hit;
  assign wr_cyc     = io_req.wr && !io_req.rd;
  assign rd_cyc     = io_req.rd && !io_req.wr;
  // soft_reset deliberately unused by every register
  assign warm_reset = hard_reset || main_por;

  localparam int ALT_MODE_MSB = rth_pkg::ALT_PIN_MODE_LSB + 1;

  assign dis_locked = (alt_pin_config_b_q[ALT_MODE_MSB:rth_pkg::ALT_PIN_MODE_LSB] == rth_pkg::ALT_PIN_MODE_LOCK)
                      && pin_sync_q;

  // pin synchronisers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ack_meta_q <= 1'b1;
      ack_sync_q <= 1'b1;
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
    end else begin
      ack_meta_q <= printer_ack_input;
      ack_sync_q <= ack_meta_q;
      pin_meta_q <= alt_pin_b_input;
      pin_sync_q <= pin_meta_q;
    end
  end

  // upper register array
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < rth_pkg::UPPER_COUNT; i++) begin
        upper_regs_q[i] <= standby_value(7'(i) + rth_pkg::UPPER_BASE);
      end
    end else begin
      for (int i = 0; i < rth_pkg::UPPER_COUNT; i++) begin
        if (warm_reset) begin
          upper_regs_q[i] <= upper_regs_q[i] & ~hard_clear(7'(i) + rth_pkg::UPPER_BASE, main_por);
        end else if (upper_hit && wr_cyc && (off[5:0] == 6'(i))) begin
          upper_regs_q[i] <= (upper_regs_q[i] & ~store_mask(off))
                             | (io_req.wdata & store_mask(off));
        end
      end
      // read-only counters and status loaded from the fan_speed_count and wdt_status_in inputs every cycle
      upper_regs_q[rth_pkg::OFF_FAN_SPEED_COUNT[5:0]] <= fan_speed_count;
      upper_regs_q[rth_pkg::OFF_WDT_CONTROL[5:0]][rth_pkg::WATCHDOG_CONTROL_STAT_BIT] <= wdt_status_in;
    end
  end

  // write-only watchdog kick bit, one-cycle pulse
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wdt_kick_q <= 1'b0;
    end else begin
      wdt_kick_q <= upper_hit && wr_cyc && (off == rth_pkg::OFF_WDT_CONTROL)
                    && io_req.wdata[rth_pkg::WATCHDOG_CONTROL_KICK_BIT];
    end
  end

  // device disable register with pin-qualified write lock
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dev_disable_q <= rth_pkg::RST_ZERO;
    end else if (dis_hit && wr_cyc && !dis_locked) begin
      dev_disable_q <= io_req.wdata;
    end
  end

  // pin 43 control register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      alt_pin_config_b_q <= rth_pkg::RST_PIN_CTL;
    end else if (warm_reset) begin
      alt_pin_config_b_q <= alt_pin_config_b_q & ~rth_pkg::ALT_PIN_MODE_MASK;
    end else if (alt_hit && wr_cyc) begin
      alt_pin_config_b_q <= io_req.wdata;
    end
  end

  // read data path
  always_comb begin
    rd_value = 8'h00;
    if (upper_hit) begin
      rd_value = upper_regs_q[off[5:0]] & read_mask(off);
    end else if (dis_hit) begin
      rd_value = dev_disable_q;
    end else if (alt_hit) begin
      rd_value = alt_pin_config_b_q;
    end
  end

  // host answer, one cycle after the request
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      io_rdata_q <= 8'h00;
      io_ack_q   <= 1'b0;
    end else begin
      io_ack_q   <= any_hit && (rd_cyc || wr_cyc);
      io_rdata_q <= (any_hit && rd_cyc) ? rd_value : 8'h00;
    end
  end

  // parallel port interrupt level
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      parallel_irq_level_q <= 1'b1;
    end else if (!par_port_active) begin
      parallel_irq_level_q <= 1'b1;
    end else begin
      parallel_irq_level_q <= ack_sync_q;
    end
  end

endmodule : rth_upper_regs

`default_nettype wire

// ===== dv/rth_upper_regs_props.sv
/* Checker for rth_upper_regs, bound to every instance.
   Assumes rst is the standby reset and host cycles are one-cycle pulses. */
`timescale 1ns/1ps
`default_nettype none
module rth_upper_regs_props (
  input wire logic                 ref_clk,
  input wire logic                 rst,
  input wire logic                 main_por,
  input wire logic                 hard_reset,
  input wire logic                 soft_reset,
  input wire logic [15:0]          base_addr,
  input wire rth_pkg::rth_io_req_s io_req,
  input wire logic                 par_port_active,
  input wire logic                 printer_ack_input,
  input wire logic                 alt_pin_b_input,
  input wire logic                 wdt_status_in,
  input wire rth_pkg::rth_byte_t   fan_speed_count,
  input wire logic [7:0]           io_rdata_q,
  input wire logic                 io_ack_q,
  input wire logic [63:0][7:0]     upper_regs_q,
  input wire logic [7:0]           dev_disable_q,
  input wire logic [7:0]           alt_pin_config_b_q,
  input wire logic                 wdt_kick_q,
  input wire logic                 parallel_irq_level_q
);
  logic [15:0] off;
  logic        hit;
  logic        rs;
  logic        rd1;
  logic        wr1;
  assign off = io_req.addr - base_addr;
  assign rd1 = io_req.rd && !io_req.wr;
  assign wr1 = io_req.wr && !io_req.rd;
  assign hit = (rd1 || wr1) && off < 16'h0080 && (off >= 16'h0040 || off == 16'h0022 || off == 16'h003E);
  assign rs  = hard_reset || main_por;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  ack_decode_a: assert property (hit |=> io_ack_q) else $error("missing ack");
  stray_ack_a: assert property (!hit |=> !io_ack_q) else $error("stray ack");
  rsvd_zero_a: assert property (rd1 && hit && off >= 16'h006D |=> io_rdata_q == 8'h00) else $error("rsvd");
  wdt_bits_a: assert property (rd1 && off == 16'h0055 |=> io_rdata_q[7:4] == 4'h0 && !io_rdata_q[2])
    else $error("wdt read bits");
  wdt_kick_a: assert property (wr1 && off == 16'h0055 && io_req.wdata[2] |=> wdt_kick_q) else $error("no kick");
  kick_only_a: assert property (!(wr1 && off == 16'h0055 && io_req.wdata[2]) |=> !wdt_kick_q)
    else $error("stray kick");
  wdt_keep_a: assert property (hard_reset && !main_por |=>
    upper_regs_q[21][1:0] == {1'b0, $past(upper_regs_q[21][0])}) else $error("wdt hard reset");
  wdt_por_a: assert property (main_por |=> upper_regs_q[21][1:0] == 2'b00) else $error("wdt por");
  fan_bit_a: assert property (rs |=> !upper_regs_q[12][3]) else $error("fan bit");
  pin_mode_a: assert property (rs |=> alt_pin_config_b_q[3:2] == 2'b00) else $error("pin mode");
  lock_a: assert property (alt_pin_b_input[*3] ##0 (wr1 && off == 16'h0022 && alt_pin_config_b_q[3:2] == 2'b01)
    |=> $stable(dev_disable_q)) else $error("lock");
  par_idle_a: assert property (!par_port_active |=> parallel_irq_level_q) else $error("par idle");
  par_track_a: assert property (par_port_active[*4] |-> parallel_irq_level_q == $past(printer_ack_input, 3))
    else $error("par track");
  soft_keep_a: assert property (soft_reset && !rs && !io_req.wr
    |=> $stable(alt_pin_config_b_q) && $stable(dev_disable_q)) else $error("soft reset");
endmodule : rth_upper_regs_props
bind rth_upper_regs rth_upper_regs_props u_props (.ref_clk(ref_clk), .rst(rst), .main_por(main_por),
  .hard_reset(hard_reset), .soft_reset(soft_reset), .base_addr(base_addr), .io_req(io_req),
  .par_port_active(par_port_active), .printer_ack_input(printer_ack_input), .alt_pin_b_input(alt_pin_b_input),
  .wdt_status_in(wdt_status_in), .fan_speed_count(fan_speed_count), .io_rdata_q(io_rdata_q), .io_ack_q(io_ack_q),
  .upper_regs_q(upper_regs_q), .dev_disable_q(dev_disable_q), .alt_pin_config_b_q(alt_pin_config_b_q),
  .wdt_kick_q(wdt_kick_q), .parallel_irq_level_q(parallel_irq_level_q));
`default_nettype wire

// ===== dv/rth_host_model.sv
/* Host model issuing decoded I/O cycles.
   Assumes the caller enters xfer just after a rising edge. */
`timescale 1ns/1ps
`default_nettype none
module rth_host_model #(
  parameter logic [15:0] BASE = 16'h0A00
) (
  input  wire logic            ref_clk,
  output var rth_pkg::rth_io_req_s io_req,
  input  wire logic [7:0]      io_rdata_q,
  input  wire logic            io_ack_q
);
  initial io_req = '0;
  // idle lines show inverted values, never the last ones
  task automatic xfer(input logic w, input logic [15:0] o, input logic [7:0] d, output logic [7:0] q, output logic a);
    io_req <= '{rd: !w, wr: w, addr: BASE + o, wdata: d};
    @(posedge ref_clk);
    #1;
    a = io_ack_q;
    q = io_rdata_q;
    io_req <= '{rd: 1'b0, wr: 1'b0, addr: ~(BASE + o), wdata: ~d};
    @(posedge ref_clk);
    #1;
  endtask : xfer
endmodule : rth_host_model
`default_nettype wire

// ===== dv/testbench.sv
/* Self-checking bench for the upper runtime register block.
   Assumes the host model and the bound checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [15:0] BASE = 16'h0A00;
  logic                 ref_clk, rst, main_por, hard_reset, soft_reset, par_act, ack_in, pin_b, wdt_st;
  logic                 io_ack_q, kick, irq_lvl, ack;
  logic [7:0]           io_rdata_q, fan_cnt, dis_q, altb_q, q;
  logic [63:0][7:0]     regs_q;
  rth_pkg::rth_io_req_s io_req;
  int                   fail_count, n_checks, cyc, kick_cnt;
  always #2.5 ref_clk = ~ref_clk;
  // kick pulses counted away from the launching edge
  always @(negedge ref_clk) begin
    if (kick === 1'b1) kick_cnt++;
  end
  rth_upper_regs dut (.ref_clk(ref_clk), .rst(rst), .main_por(main_por), .hard_reset(hard_reset),
    .soft_reset(soft_reset), .base_addr(BASE), .io_req(io_req), .par_port_active(par_act),
    .printer_ack_input(ack_in), .alt_pin_b_input(pin_b), .wdt_status_in(wdt_st), .fan_speed_count(fan_cnt),
    .io_rdata_q(io_rdata_q), .io_ack_q(io_ack_q), .upper_regs_q(regs_q), .dev_disable_q(dis_q),
    .alt_pin_config_b_q(altb_q), .wdt_kick_q(kick), .parallel_irq_level_q(irq_lvl));
  rth_host_model #(.BASE(BASE)) host (.ref_clk(ref_clk), .io_req(io_req), .io_rdata_q(io_rdata_q), .io_ack_q(io_ack_q));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [15:0] o, input logic [7:0] exp);
    host.xfer(1'b0, o, 8'h00, q, ack);
    chk({7'h00, ack}, 8'h01);
    chk(q, exp);
  endtask : rd
  task automatic wr(input logic [15:0] o, input logic [7:0] d);
    host.xfer(1'b1, o, d, q, ack);
    chk({7'h00, ack}, 8'h01);
  endtask : wr
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(posedge ref_clk);
    #1 s = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask : pulse
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : wait_cyc
  task automatic t_reset_vals;
    logic [15:0] offs [8] = '{16'h0040, 16'h0041, 16'h0043, 16'h0044, 16'h0047, 16'h0058, 16'h003E, 16'h0022};
    logic [7:0]  exps [8] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h10, 8'h01, 8'h00};
    for (int i = 0; i < 8; i++) rd(offs[i], exps[i]);
    for (int o = 16'h004B; o <= 16'h0050; o++) rd(o[15:0], 8'h00);
    rd(16'h0055, 8'h00);
  endtask : t_reset_vals
  task automatic t_access;
    wr(16'h005D, 8'hA5);
    rd(16'h005D, 8'hA5);
    wr(16'h0049, 8'hFF);
    rd(16'h0049, 8'h00);
    for (int o = 16'h006D; o <= 16'h007F; o++) begin
      wr(o[15:0], 8'hFF);
      rd(o[15:0], 8'h00);
    end
    fan_cnt = 8'h3C;
    wr(16'h0059, 8'hFF);
    rd(16'h0059, 8'h3C);
    host.xfer(1'b0, 16'h0010, 8'h00, q, ack);
    chk({7'h00, ack}, 8'h00);
    host.xfer(1'b1, 16'h0080, 8'h00, q, ack);
    chk({7'h00, ack}, 8'h00);
  endtask : t_access
  task automatic t_wdt;
    wdt_st = 1'b1;
    wr(16'h0052, 8'h77);
    wr(16'h0055, 8'hFF);
    chk(8'(kick_cnt), 8'h01);
    rd(16'h0055, 8'h0B);
    pulse(soft_reset);
    rd(16'h0055, 8'h0B);
    rd(16'h0052, 8'h77);
    rd(16'h0041, 8'h01);
    pulse(hard_reset);
    rd(16'h0055, 8'h09);
    rd(16'h0052, 8'h00);
    rd(16'h0041, 8'h00);
    rd(16'h005D, 8'hA5);
    pulse(main_por);
    rd(16'h0055, 8'h08);
    chk(8'(kick_cnt), 8'h01);
  endtask : t_wdt
  task automatic t_lock;
    wr(16'h004C, 8'hFF);
    wr(16'h003E, 8'h04);
    pin_b = 1'b1;
    wait_cyc(3);
    wr(16'h0022, 8'h5A);
    rd(16'h0022, 8'h00);
    pin_b = 1'b0;
    wait_cyc(3);
    wr(16'h0022, 8'h5A);
    rd(16'h0022, 8'h5A);
    pulse(hard_reset);
    rd(16'h003E, 8'h00);
    rd(16'h004C, 8'hF7);
    rd(16'h0022, 8'h5A);
  endtask : t_lock
  task automatic t_par;
    ack_in = 1'b0;
    wait_cyc(4);
    chk({7'h00, irq_lvl}, 8'h01);
    par_act = 1'b1;
    wait_cyc(4);
    chk({7'h00, irq_lvl}, 8'h00);
    ack_in = 1'b1;
    wait_cyc(4);
    chk({7'h00, irq_lvl}, 8'h01);
  endtask : t_par
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      test_done();
    end
  end
  initial begin
    {ref_clk, main_por, hard_reset, soft_reset, par_act, pin_b, wdt_st} = '0;
    {rst, ack_in} = 2'b11;
    {fan_cnt, fail_count, n_checks, cyc, kick_cnt} = '0;
    repeat (8) @(posedge ref_clk);
    #1 rst = 1'b0;
    wait_cyc(1);
    t_reset_vals();
    t_access();
    t_wdt();
    t_lock();
    t_par();
    test_done();
  end
endmodule : testbench
`default_nettype wire
